// file: testbench/psag_checker.sv
// Checker for the program space address generator
`include "psag_defs.vh"
module psag_checker (
   input wire clock,
   input wire rstn,
   input wire tbl_req,
   input wire tbl_write,
   input wire tbl_byte,
   input wire tbl_upper,
   input wire data_req,
   input wire data_write,
   input wire [`PSAG_DW-1:0] effective_address,
   input wire [`PSAG_PAGE_W-1:0] table_page_register,
   input wire [`PSAG_PAGE_W-1:0] visibility_page_register,
   input wire pm_req,
   input wire pm_write,
   input wire [`PSAG_PW-1:0] pm_addr,
   input wire [2:0] pm_byte_en,
   input wire pm_config,
   input wire pm_rvalid,
   input wire rvalid,
   input wire [`PSAG_DW-1:0] rdata,
   input wire dm_req,
   input wire [`PSAG_DW-1:0] dm_addr,
   input wire dm_rvalid,
   input wire [`PSAG_DW-1:0] dm_rdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence tbl_s; tbl_req ##1 pm_req; endsequence
   sequence vis_s; data_req && !tbl_req && effective_address[15] ##1 pm_req; endsequence
   tbl_addr_a: assert property (tbl_s |-> pm_addr ==
      {$past(table_page_register), $past(effective_address)}) else $error("table address");
   vis_addr_a: assert property (vis_s |-> pm_addr ==
      {1'b0, $past(visibility_page_register), $past(effective_address[14:0])})
      else $error("visibility address");
   space_sel_a: assert property (pm_req |-> pm_config == pm_addr[23]) else $error("space");
   read_only_a: assert property (data_req && data_write && effective_address[15] && !tbl_req
      |=> !pm_req && !dm_req) else $error("visibility write");
   data_path_a: assert property (dm_req |-> !pm_req && !dm_addr[15]) else $error("data");
   tbl_read_a: assert property (tbl_req && !tbl_write ##1 pm_req |-> !pm_write)
      else $error("table read");
   upper_byte_a: assert property (tbl_req && tbl_byte && tbl_upper ##1 pm_req
      |-> pm_byte_en == 3'h4) else $error("upper byte");
   pm_answer_a: assert property (pm_rvalid |=> rvalid) else $error("program answer");
   dm_answer_a: assert property (dm_rvalid |=> rvalid && rdata == $past(dm_rdata))
      else $error("data answer");
endmodule
bind psag_top psag_checker chk (.*);

// file: testbench/psag_mem_model.sv
// Program and data memory model answering the generator
module psag_mem_model (
   input wire logic clock,
   input wire logic slow,
   input wire logic pm_req,
   input wire logic pm_write,
   input wire logic [23:0] pm_addr,
   input wire logic dm_req,
   input wire logic dm_write,
   input wire logic [15:0] dm_addr,
   output logic [23:0] pm_rdata = 24'h0,
   output logic pm_rvalid = 1'b0,
   output logic [15:0] dm_rdata = 16'h0,
   output logic dm_rvalid = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend = 1'b0, prog = 1'b0;
   logic [2:0] cnt = 3'h0;
   always @(posedge clock) begin
      pm_rvalid <= 1'b0;
      dm_rvalid <= 1'b0;
      pm_rdata <= ~pm_rdata;
      dm_rdata <= ~dm_rdata;
      if ((pm_req && !pm_write) || (dm_req && !dm_write)) begin
         pend <= 1'b1;
         prog <= pm_req;
         cnt <= slow ? 3'h4 : 3'h0;
      end else if (pend && cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end else if (pend) begin
         pend <= 1'b0;
         pm_rvalid <= prog;
         dm_rvalid <= !prog;
         if (prog) pm_rdata <= {pm_addr[23:16] ^ pm_addr[7:0], pm_addr[15:0] ^ 16'h3c3c};
         else dm_rdata <= dm_addr ^ 16'h9e37;
      end
   end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the program space address generator
`include "psag_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rstn = 0, page_we = 0, page_sel = 0, tbl_req = 0, tbl_write = 0, slow = 0;
   logic tbl_byte = 0, tbl_upper = 0, data_req = 0, data_write = 0, rvalid, pm_req, pm_write;
   logic pm_config, pm_rvalid, dm_req, dm_write, dm_rvalid;
   logic [2:0] pm_byte_en;
   logic [7:0] page_wdata = 0, table_page_register, visibility_page_register, tp = 0, vp = 0;
   logic [15:0] effective_address = 0, tbl_wdata = 0, data_wdata = 0, rnd = 16'h0045;
   logic [15:0] rdata, dm_addr, dm_wdata, dm_rdata;
   logic [23:0] pm_addr, pm_wdata, pm_rdata;
   int errors = 0, compares = 0;
   psag_top DUT (.*);
   psag_mem_model mem (.*);
   initial forever #50 clock = ~clock;
   function automatic [15:0] lfsr(input [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic [23:0] paddr(input t, input [15:0] ea);
      return t ? {tp, ea} : {1'b0, vp, ea[14:0]};
   endfunction
   function automatic [2:0] be_want(input t, b, u, input [15:0] ea);
      if (!t || (!u && !b)) return 3'h3;
      if (u) return 3'h4;
      return ea[0] ? 3'h2 : 3'h1;
   endfunction
   function automatic [23:0] wd_want(input b, u, input [15:0] d);
      if (u) return {d[7:0], 16'h0000};
      if (b) return {8'h00, d[7:0], d[7:0]};
      return {8'h00, d};
   endfunction
   function automatic [15:0] want(input t, b, u, input [15:0] ea);
      logic [23:0] a, w;
      a = paddr(t, ea);
      w = {a[23:16] ^ a[7:0], a[15:0] ^ 16'h3c3c};
      if (!t && !ea[15]) return ea ^ 16'h9e37;
      if (t && u) return {8'h00, w[23:16]};
      if (t && b) return {8'h00, ea[0] ? w[15:8] : w[7:0]};
      return w[15:0];
   endfunction
   task close_out;
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input [39:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task tick;
      @(posedge clock);
      #1;
   endtask
   task setpg(input s, input [7:0] v);
      tick;
      {page_we, page_sel, page_wdata} = {1'b1, s, v};
      if (s) vp = v;
      else tp = v;
      tick;
      page_we = 0;
      chk({table_page_register, visibility_page_register}, {tp, vp});
   endtask
   task req(input t, w, b, u, input [15:0] ea);
      int n;
      logic [23:0] pa;
      logic pe, de;
      tick;
      {tbl_req, data_req, tbl_write, data_write} = {t, !t, w, w};
      {tbl_byte, tbl_upper, effective_address} = {b, u, ea};
      {tbl_wdata, data_wdata} = {rnd, ~rnd};
      tick;
      {tbl_req, data_req} = 2'b00;
      n = 0;
      pa = paddr(t, ea);
      pe = t || (!w && ea[15]);
      de = !t && !ea[15];
      chk({pm_req, dm_req}, {pe, de});
      if (pe) chk({pm_config, pm_write, pm_byte_en, pm_addr},
         {pa[23], w, be_want(t, b, u, ea), pa});
      if (pe && w) chk(pm_wdata, wd_want(b, u, rnd));
      if (de) chk({dm_write, dm_addr, dm_wdata}, {w, ea, ~rnd});
      while (!w && rvalid !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      if (!w) chk(rvalid ? rdata : ~want(t, b, u, ea), want(t, b, u, ea));
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 rstn = 1;
      chk({table_page_register, visibility_page_register, rvalid, pm_req, dm_req}, 19'h0);
      setpg(0, 8'hff);
      setpg(1, 8'hff);
      req(1, 0, 1, 1, 16'hffff);
      req(0, 0, 0, 0, 16'h8001);
      req(1, 0, 1, 0, 16'h0001);
      req(0, 1, 0, 0, 16'hffff);
      for (int i = 0; i < 200; i++) begin
         rnd = lfsr(rnd);
         slow = rnd[6];
         if (rnd[7]) setpg(rnd[8], rnd[15:8]);
         req(rnd[1], rnd[3:2] == 2'h0, rnd[4], rnd[5], lfsr(rnd));
      end
      rstn = 0;
      tick;
      chk({table_page_register, visibility_page_register, rvalid, pm_req, dm_req}, 19'h0);
      rstn = 1;
      {tp, vp} = 16'h0000;
      req(1, 0, 0, 0, 16'h1234);
      req(0, 0, 0, 0, 16'h8765);
      close_out;
   end
   initial begin
      repeat (10000) @(posedge clock);
      errors++;
      close_out;
   end
endmodule

// file: verilog/psag_defs.vh
// Constants for the program space address generator
`ifndef PSAG_DEFS_VH
`define PSAG_DEFS_VH
// ********************
// Widths and positions
// ********************
`define PSAG_PW 24
`define PSAG_DW 16
`define PSAG_PAGE_W 8
`define PSAG_SPACE_BIT 7
`define PSAG_VIS_BIT 15
`define PSAG_VIS_LOW_W 15
`define PSAG_PAGE_RST 8'h00
`define PSAG_BYTE_LO 2'h0
`define PSAG_BYTE_MID 2'h1
`define PSAG_BYTE_UP 2'h2
`define PSAG_BE_LO 3'h1
`define PSAG_BE_MID 3'h2
`define PSAG_BE_UP 3'h4
`define PSAG_BE_WORD 3'h3
`endif

// file: verilog/psag_table_addr.v
// Table path address former
`include "psag_defs.vh"
module psag_table_addr (
   input wire [`PSAG_PAGE_W-1:0] table_page,
   input wire [`PSAG_DW-1:0] effective_address,
   output wire [`PSAG_PW-1:0] prog_addr,
   output wire config_space
);
   // ****************
   // Address forming
   // ****************
   assign prog_addr = {table_page, effective_address};
   assign config_space = table_page[`PSAG_SPACE_BIT];
endmodule

// file: verilog/psag_top.v
// Program space address generator top
`include "psag_defs.vh"
module psag_top (
   input wire clock,
   input wire rstn,
   input wire page_we,
   input wire page_sel,
   input wire [`PSAG_PAGE_W-1:0] page_wdata,
   input wire tbl_req,
   input wire tbl_write,
   input wire tbl_byte,
   input wire tbl_upper,
   input wire [`PSAG_DW-1:0] effective_address,
   input wire [`PSAG_DW-1:0] tbl_wdata,
   input wire data_req,
   input wire data_write,
   input wire [`PSAG_DW-1:0] data_wdata,
   output reg [`PSAG_DW-1:0] rdata,
   output reg rvalid,
   output wire [`PSAG_PAGE_W-1:0] table_page_register,
   output wire [`PSAG_PAGE_W-1:0] visibility_page_register,
   output reg pm_req,
   output reg pm_write,
   output reg [`PSAG_PW-1:0] pm_addr,
   output reg [`PSAG_PW-1:0] pm_wdata,
   output reg [2:0] pm_byte_en,
   output reg pm_config,
   input wire [`PSAG_PW-1:0] pm_rdata,
   input wire pm_rvalid,
   output reg dm_req,
   output reg dm_write,
   output reg [`PSAG_DW-1:0] dm_addr,
   output reg [`PSAG_DW-1:0] dm_wdata,
   input wire [`PSAG_DW-1:0] dm_rdata,
   input wire dm_rvalid
);
   localparam ST_IDLE = 3'b001;
   localparam ST_TBL = 3'b010;
   localparam ST_VIS = 3'b100;
   reg [`PSAG_PAGE_W-1:0] tpage;
   reg [`PSAG_PAGE_W-1:0] vpage;
   reg [2:0] state;
   reg [1:0] lane;
   reg lane_byte;
   wire [`PSAG_PW-1:0] tbl_addr;
   wire tbl_cfg;
   wire [`PSAG_PW-1:0] vis_addr;
   wire vis_hit;

   reg [2:0] next_state;
   reg next_pm_req;
   reg next_pm_write;
   reg [`PSAG_PW-1:0] next_pm_addr;
   reg [`PSAG_PW-1:0] next_pm_wdata;
   reg [2:0] next_pm_byte_en;
   reg next_pm_config;
   reg next_dm_req;
   reg next_dm_write;
   reg [`PSAG_DW-1:0] next_dm_addr;
   reg [`PSAG_DW-1:0] next_dm_wdata;
   reg [`PSAG_DW-1:0] next_rdata;
   reg next_rvalid;
   reg [1:0] next_lane;
   reg next_lane_byte;
   wire idle;
   wire take_tbl;
   wire take_vis;
   wire take_data;
   assign table_page_register = tpage;
   assign visibility_page_register = vpage;
   psag_table_addr u_tbl (
      .table_page(tpage),
      .effective_address(effective_address),
      .prog_addr(tbl_addr),
      .config_space(tbl_cfg)
   );
   psag_vis_addr u_vis (
      .vis_page(vpage),
      .effective_address(effective_address),
      .prog_addr(vis_addr),
      .vis_hit(vis_hit)
   );
   // Byte lane select from address bit 0 and upper flag
   function [1:0] lane_of;
      input up;
      input a0;
      begin
         if (up)
            lane_of = `PSAG_BYTE_UP;
         else if (a0)
            lane_of = `PSAG_BYTE_MID;
         else
            lane_of = `PSAG_BYTE_LO;
      end
   endfunction

   // Byte enables of a table access
   function [2:0] byte_en_of;
      input up;
      input byte_op;
      input a0;
      begin
         if (up)
            byte_en_of = `PSAG_BE_UP;
         else if (byte_op)
            byte_en_of = a0 ? `PSAG_BE_MID : `PSAG_BE_LO;
         else
            byte_en_of = `PSAG_BE_WORD;
      end
   endfunction

   // Program write word from core write data
   function [`PSAG_PW-1:0] wdata_of;
      input up;
      input byte_op;
      input [`PSAG_DW-1:0] wd;
      begin
         if (up)
            wdata_of = {wd[7:0], 16'h0000};
         else if (byte_op)
            wdata_of = {8'h00, wd[7:0], wd[7:0]};
         else
            wdata_of = {8'h00, wd};
      end
   endfunction

   // Read result picked from a program word
   function [`PSAG_DW-1:0] lane_data;
      input [1:0] ln;
      input byte_op;
      input [`PSAG_PW-1:0] word;
      begin
         if (ln == `PSAG_BYTE_UP)
            lane_data = {8'h00, word[23:16]};
         else if (!byte_op)
            lane_data = word[15:0];
         else if (ln == `PSAG_BYTE_MID)
            lane_data = {8'h00, word[15:8]};
         else
            lane_data = {8'h00, word[7:0]};
      end
   endfunction
   // ****************
   // Page registers
   // ****************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tpage <= `PSAG_PAGE_RST;
         vpage <= `PSAG_PAGE_RST;
      end else if (page_we) begin
         if (page_sel)
            vpage <= page_wdata;
         else
            tpage <= page_wdata;
      end
   end
   // ****************
   // Request decode
   // ****************
   assign idle = (state == ST_IDLE);
   assign take_tbl = idle && tbl_req;
   assign take_vis = idle && !tbl_req && data_req && vis_hit && !data_write;
   assign take_data = idle && !tbl_req && data_req && !vis_hit;

   // ****************
   // Next state
   // ****************
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take_tbl && !tbl_write)
               next_state = ST_TBL;
            else if (take_vis)
               next_state = ST_VIS;
         end
         ST_TBL: begin
            if (pm_rvalid)
               next_state = ST_IDLE;
         end
         ST_VIS: begin
            if (pm_rvalid)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ****************
   // Program request
   // ****************
   always @* begin
      next_pm_req = 1'b0;
      next_pm_write = pm_write;
      next_pm_addr = pm_addr;
      next_pm_wdata = pm_wdata;
      next_pm_byte_en = pm_byte_en;
      next_pm_config = pm_config;
      next_lane = lane;
      next_lane_byte = lane_byte;
      if (take_tbl) begin
         next_pm_req = 1'b1;
         next_pm_write = tbl_write;
         next_pm_addr = tbl_addr;
         next_pm_config = tbl_cfg;
         next_pm_wdata = wdata_of(tbl_upper, tbl_byte, tbl_wdata);
         next_pm_byte_en = byte_en_of(tbl_upper, tbl_byte, effective_address[0]);
         next_lane = lane_of(tbl_upper, effective_address[0]);
         next_lane_byte = tbl_byte;
      end else if (take_vis) begin
         next_pm_req = 1'b1;
         next_pm_write = 1'b0;
         next_pm_addr = vis_addr;
         next_pm_config = 1'b0;
         next_pm_byte_en = `PSAG_BE_WORD;
      end
   end

   // ****************
   // Data request
   // ****************
   always @* begin
      next_dm_req = 1'b0;
      next_dm_write = dm_write;
      next_dm_addr = dm_addr;
      next_dm_wdata = dm_wdata;
      if (take_data) begin
         next_dm_req = 1'b1;
         next_dm_write = data_write;
         next_dm_addr = effective_address;
         next_dm_wdata = data_wdata;
      end
   end

   // ****************
   // Read return
   // ****************
   always @* begin
      next_rvalid = 1'b0;
      next_rdata = rdata;
      case (state)
         ST_IDLE: begin
            if (dm_rvalid) begin
               next_rvalid = 1'b1;
               next_rdata = dm_rdata;
            end
         end
         ST_TBL: begin
            if (pm_rvalid) begin
               next_rvalid = 1'b1;
               next_rdata = lane_data(lane, lane_byte, pm_rdata);
            end
         end
         ST_VIS: begin
            if (pm_rvalid) begin
               next_rvalid = 1'b1;
               next_rdata = pm_rdata[`PSAG_DW-1:0];
            end
         end
         default: begin
            next_rvalid = 1'b0;
         end
      endcase
   end

   // ****************
   // Output registers
   // ****************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         pm_req <= 1'b0;
         pm_write <= 1'b0;
         pm_addr <= {`PSAG_PW{1'b0}};
         pm_wdata <= {`PSAG_PW{1'b0}};
         pm_byte_en <= 3'h0;
         pm_config <= 1'b0;
         dm_req <= 1'b0;
         dm_write <= 1'b0;
         dm_addr <= {`PSAG_DW{1'b0}};
         dm_wdata <= {`PSAG_DW{1'b0}};
         rdata <= {`PSAG_DW{1'b0}};
         rvalid <= 1'b0;
         lane <= 2'h0;
         lane_byte <= 1'b0;
      end else begin
         state <= next_state;
         pm_req <= next_pm_req;
         pm_write <= next_pm_write;
         pm_addr <= next_pm_addr;
         pm_wdata <= next_pm_wdata;
         pm_byte_en <= next_pm_byte_en;
         pm_config <= next_pm_config;
         dm_req <= next_dm_req;
         dm_write <= next_dm_write;
         dm_addr <= next_dm_addr;
         dm_wdata <= next_dm_wdata;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         lane <= next_lane;
         lane_byte <= next_lane_byte;
      end
   end
endmodule

// file: verilog/psag_vis_addr.v
// Visibility path address former
`include "psag_defs.vh"
module psag_vis_addr (
   input wire [`PSAG_PAGE_W-1:0] vis_page,
   input wire [`PSAG_DW-1:0] effective_address,
   output wire [`PSAG_PW-1:0] prog_addr,
   output wire vis_hit
);
   // ****************
   // Address forming
   // ****************
   assign prog_addr = {1'b0, vis_page, effective_address[`PSAG_VIS_LOW_W-1:0]};
   assign vis_hit = effective_address[`PSAG_VIS_BIT];
endmodule
